// ===== rtl/alu_exec.sv
// Execution datapath for literal/register add and AND, bit clear/set and bit tests.
// Assumes the core presents the addressed file register's value with the instruction
// on the same clock, and flags it when that register is an I/O port.
`timescale 1ns/10ps
module alu_exec
  import alu_exec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire instr_t instr_i,
  input wire logic [DATA_W-1:0] file_rdata_i,
  input wire logic file_is_io_i,
  input wire logic [DATA_W-1:0] pin_level_i,
  output logic [DATA_W-1:0] acc_o,
  output status_t status_o,
  output file_wr_t file_wr_o,
  output logic skip_o
);

  typedef struct packed {
    logic [DATA_W-1:0] pin_meta;
    logic [DATA_W-1:0] pin_sync;
    logic [DATA_W-1:0] acc;
    status_t flags;
    file_wr_t wr;
    logic skip_pend;
    logic skip;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // Decode the instruction word into one of the handled operations
  function automatic op_t decode_op(input logic [INSTR_W-1:0] w);
    op_t op;
    op = OP_NONE;
    if (w[OPC_MSB:OPC5_LSB] == ADD_LIT_CODE) begin
      op = OP_ADD_LIT;
    end else if (w[OPC_MSB:OPC6_LSB] == AND_LIT_CODE) begin
      op = OP_AND_LIT;
    end else if (w[OPC_MSB:OPC6_LSB] == ADD_REG_CODE) begin
      op = OP_ADD_REG;
    end else if (w[OPC_MSB:OPC6_LSB] == AND_REG_CODE) begin
      op = OP_AND_REG;
    end else begin
      case (w[OPC_MSB:OPC4_LSB])
        BCLR_CODE: op = OP_BIT_CLR;
        BSET_CODE: op = OP_BIT_SET;
        BTSZ_CODE: op = OP_SKIP_ZERO;
        BTSO_CODE: op = OP_SKIP_ONE;
        default: op = OP_NONE;
      endcase
    end
    return op;
  endfunction

  // Add with carry out of bit 7 and out of bit 3
  function automatic logic [DATA_W+1:0] add_flags(input logic [DATA_W-1:0] a,
                                                  input logic [DATA_W-1:0] b);
    logic [DATA_W:0] sum;
    logic [NIBBLE_MSB+1:0] nib;
    sum = {1'b0, a} + {1'b0, b};
    nib = {1'b0, a[NIBBLE_MSB:0]} + {1'b0, b[NIBBLE_MSB:0]};
    return {nib[NIBBLE_MSB+1], sum};
  endfunction

  op_t op;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] literal;
  logic [DATA_W+1:0] lit_add;
  logic [DATA_W+1:0] reg_add;
  logic [DATA_W-1:0] bit_mask;
  logic to_file;
  logic tested_bit;

  // Operand selection and arithmetic shared by the state update
  always_comb begin
    op = decode_op(instr_i.word);
    literal = instr_i.word[DATA_W-1:0];
    // Pin levels, not latch contents, for I/O ports; costs two cycles of pin lag
    operand = file_is_io_i ? state_reg.pin_sync : file_rdata_i;
    lit_add = add_flags(state_reg.acc, literal);
    reg_add = add_flags(state_reg.acc, operand);
    bit_mask = 8'h01 << instr_i.word[BITSEL_MSB:BITSEL_LSB];
    to_file = instr_i.word[DEST_POS];
    tested_bit = |(operand & bit_mask);
  end

  // Next state: one instruction per clock, discarded when a skip is pending
  always_comb begin
    state_next = state_reg;
    state_next.pin_meta = pin_level_i;
    state_next.pin_sync = state_reg.pin_meta;
    state_next.wr.en = 1'b0;
    state_next.skip = 1'b0;
    if (instr_i.valid && state_reg.skip_pend) begin
      // Discarded slot runs as a no-operation
      state_next.skip_pend = 1'b0;
    end else if (instr_i.valid) begin
      state_next.wr.addr = instr_i.word[FADDR_W-1:0];
      case (op)
        OP_ADD_LIT: begin
          state_next.acc = lit_add[DATA_W-1:0];
          state_next.flags.carry = lit_add[DATA_W];
          state_next.flags.nibble_overflow_flag = lit_add[DATA_W+1];
          state_next.flags.zero = (lit_add[DATA_W-1:0] == 8'h00);
        end
        OP_ADD_REG: begin
          if (to_file) begin
            state_next.wr.en = 1'b1;
            state_next.wr.data = reg_add[DATA_W-1:0];
          end else begin
            state_next.acc = reg_add[DATA_W-1:0];
          end
          state_next.flags.carry = reg_add[DATA_W];
          state_next.flags.nibble_overflow_flag = reg_add[DATA_W+1];
          state_next.flags.zero = (reg_add[DATA_W-1:0] == 8'h00);
        end
        OP_AND_LIT: begin
          state_next.acc = state_reg.acc & literal;
          state_next.flags.zero = ((state_reg.acc & literal) == 8'h00);
        end
        OP_AND_REG: begin
          if (to_file) begin
            state_next.wr.en = 1'b1;
            state_next.wr.data = state_reg.acc & operand;
          end else begin
            state_next.acc = state_reg.acc & operand;
          end
          state_next.flags.zero = ((state_reg.acc & operand) == 8'h00);
        end
        OP_BIT_CLR: begin
          state_next.wr.en = 1'b1;
          state_next.wr.data = operand & ~bit_mask;
        end
        OP_BIT_SET: begin
          state_next.wr.en = 1'b1;
          state_next.wr.data = operand | bit_mask;
        end
        OP_SKIP_ZERO: begin
          state_next.skip_pend = ~tested_bit;
          state_next.skip = ~tested_bit;
        end
        OP_SKIP_ONE: begin
          state_next.skip_pend = tested_bit;
          state_next.skip = tested_bit;
        end
        default: begin
          // Instructions owned by other blocks leave accumulator, flags and pending skip alone; wr.addr still takes the word's low bits
        end
      endcase
    end
  end

  // Single state register, synchronous reset
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_reg.pin_meta <= PIN_RST;
      state_reg.pin_sync <= PIN_RST;
      state_reg.acc <= ACC_RST;
      state_reg.flags <= '0;
      state_reg.wr.en <= 1'b0;
      state_reg.wr.addr <= ADDR_RST;
      state_reg.wr.data <= ACC_RST;
      state_reg.skip_pend <= 1'b0;
      state_reg.skip <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign acc_o = state_reg.acc;
  assign status_o = state_reg.flags;
  assign file_wr_o = state_reg.wr;
  assign skip_o = state_reg.skip;

endmodule // alu_exec

// ===== rtl/alu_exec_pkg.sv
// Constants, opcode layout and carrier types for the add / and / bit execution block.
// Assumes a core that issues one 14-bit instruction word per instruction clock.
//
// Operation
// - Literal add: accumulator plus 8-bit immediate goes back into the accumulator.
// - Register add: accumulator plus addressed file register goes to the chosen destination.
// - Destination bit 0 writes the accumulator, 1 writes the source file register.
// - Both adds update carry, nibble overflow and zero flags from the result.
// - Literal AND: accumulator AND immediate into accumulator; only zero flag changes.
// - Register AND: accumulator AND file register to destination; only zero flag changes.
// - Bit clear forces the selected bit of the file register to zero, no flags.
// - Bit set forces the selected bit of the file register to one, no flags.
// - Skip-if-zero discards the next instruction when the tested bit is zero.
// - Skip-if-one discards the next instruction when the tested bit is one.
// - I/O registers modified from themselves use the pin levels as operand.
package alu_exec_pkg;

  localparam int DATA_W = 8;
  localparam int INSTR_W = 14;
  localparam int FADDR_W = 7;

  // Field positions inside the instruction word
  localparam int DEST_POS = 7;
  localparam int BITSEL_LSB = 7;
  localparam int BITSEL_MSB = 9;
  localparam int NIBBLE_MSB = 3;
  localparam int OPC_MSB = 13;
  localparam int OPC6_LSB = 8;
  localparam int OPC5_LSB = 9;
  localparam int OPC4_LSB = 10;

  // Opcode match values, compared against the upper bits of the word
  localparam logic [5:0] ADD_REG_CODE = 6'h07;   // bits 13:8
  localparam logic [5:0] AND_REG_CODE = 6'h05;   // bits 13:8
  localparam logic [3:0] BCLR_CODE = 4'h4;     // bits 13:10
  localparam logic [3:0] BSET_CODE = 4'h5;     // bits 13:10
  localparam logic [3:0] BTSZ_CODE = 4'h6;     // bits 13:10
  localparam logic [3:0] BTSO_CODE = 4'h7;     // bits 13:10
  localparam logic [4:0] ADD_LIT_CODE = 5'h1F;   // bits 13:9
  localparam logic [5:0] AND_LIT_CODE = 6'h39;   // bits 13:8

  // Values after reset
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [DATA_W-1:0] PIN_RST = 8'h00;
  localparam logic [FADDR_W-1:0] ADDR_RST = 7'h00;

  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_ADD_LIT = 4'b0001,
    OP_ADD_REG = 4'b0010,
    OP_AND_LIT = 4'b0011,
    OP_AND_REG = 4'b0100,
    OP_BIT_CLR = 4'b0101,
    OP_BIT_SET = 4'b0110,
    OP_SKIP_ZERO = 4'b0111,
    OP_SKIP_ONE = 4'b1000
  } op_t;

  typedef struct packed {
    logic valid;
    logic [INSTR_W-1:0] word;
  } instr_t;

  typedef struct packed {
    logic carry;
    logic nibble_overflow_flag;
    logic zero;
  } status_t;

  typedef struct packed {
    logic en;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } file_wr_t;

endpackage

// ===== testbench/alu_exec_monitor.sv
// Port checks for alu_exec, bound to each instance.
// Assumes non-I/O operands; pin-fed operands are judged by the bench.
`timescale 1ns/10ps
module alu_exec_monitor
  import alu_exec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire instr_t instr_i,
  input wire logic [DATA_W-1:0] file_rdata_i,
  input wire logic file_is_io_i,
  input wire logic [DATA_W-1:0] acc_o,
  input wire status_t status_o,
  input wire file_wr_t file_wr_o,
  input wire logic skip_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic pend_reg, pend_next, tbit, ok;
  logic [13:0] w;
  logic [8:0] sum;
  logic [4:0] nib;
  // Pending skip lasts across gaps until the next valid word
  always_comb begin
    w = instr_i.word;
    pend_next = (skip_o | pend_reg) & ~instr_i.valid;
    ok = instr_i.valid & ~(skip_o | pend_reg) & ~file_is_io_i;
    tbit = file_rdata_i[w[9:7]];
    sum = {1'b0, acc_o} + {1'b0, w[7:0]};
    nib = {1'b0, acc_o[3:0]} + {1'b0, w[3:0]};
  end
  always_ff @(posedge ref_clk_i) begin
    pend_reg <= sys_rst_i ? 1'b0 : pend_next;
  end
  sequence s_dropped; instr_i.valid && (skip_o || pend_reg); endsequence
  property p_add_lit; ok && w[13:9] == 5'h1F |=> {status_o.carry, acc_o} == $past(sum)
    && status_o.nibble_overflow_flag == $past(nib[4]) && status_o.zero == (acc_o == 8'h00);
  endproperty
  property p_add_reg; ok && w[13:7] == 7'h0F |=> file_wr_o.en
    && file_wr_o.addr == 7'($past(w)) && file_wr_o.data == 8'($past(acc_o) + $past(file_rdata_i));
  endproperty
  property p_dest; ok && w[7] == 1'b0 && (w[13:8] == 6'h07 || w[13:8] == 6'h05)
    |=> !file_wr_o.en; endproperty
  property p_and_lit; ok && w[13:8] == 6'h39 |=> acc_o == ($past(acc_o) & 8'($past(w)))
    && $stable(status_o[2:1]) && status_o.zero == (acc_o == 8'h00); endproperty
  property p_and_reg; ok && w[13:7] == 7'h0B
    |=> file_wr_o.data == ($past(acc_o) & $past(file_rdata_i)) && $stable(status_o[2:1]);
  endproperty
  property p_bit_clr; ok && w[13:10] == 4'h4 |=> file_wr_o.en && $stable(status_o)
    && file_wr_o.data == ($past(file_rdata_i) & ~(8'h01 << $past(w[9:7]))); endproperty
  property p_bit_set; ok && w[13:10] == 4'h5 |=> file_wr_o.en && $stable(status_o)
    && file_wr_o.data == ($past(file_rdata_i) | (8'h01 << $past(w[9:7]))); endproperty
  property p_skip_zero; ok && w[13:10] == 4'h6 |=> skip_o == !$past(tbit); endproperty
  property p_skip_one; ok && w[13:10] == 4'h7 |=> skip_o == $past(tbit); endproperty
  property p_drop; s_dropped |=> $stable(acc_o) && $stable(status_o) && !file_wr_o.en;
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("literal add wrong");
  a_add_reg: assert property (p_add_reg) else $error("register add wrong");
  a_dest: assert property (p_dest) else $error("write to file on d=0");
  a_and_lit: assert property (p_and_lit) else $error("literal and wrong");
  a_and_reg: assert property (p_and_reg) else $error("register and wrong");
  a_bit_clr: assert property (p_bit_clr) else $error("bit clear wrong");
  a_bit_set: assert property (p_bit_set) else $error("bit set wrong");
  a_skip_zero: assert property (p_skip_zero) else $error("skip on zero wrong");
  a_skip_one: assert property (p_skip_one) else $error("skip on one wrong");
  a_drop: assert property (p_drop) else $error("skipped word executed");
endmodule // alu_exec_monitor
bind alu_exec alu_exec_monitor alu_exec_monitor_inst (.ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i), .instr_i(instr_i), .file_rdata_i(file_rdata_i),
  .file_is_io_i(file_is_io_i), .acc_o(acc_o), .status_o(status_o),
  .file_wr_o(file_wr_o), .skip_o(skip_o));

// ===== testbench/tb.sv
// Self-checking bench for alu_exec, one task per scenario.
// Assumes the bench plays the core: words, operands and pins.
`timescale 1ns/10ps
module tb;
  import alu_exec_pkg::*;
  logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, file_is_io_i = 1'b0, skip_o;
  instr_t instr_i = '0;
  logic [7:0] file_rdata_i = 8'h00, pin_level_i = 8'h00, acc_o;
  status_t status_o;
  file_wr_t file_wr_o;
  int failures = 0, n_tests = 0;
  alu_exec alu_exec_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .instr_i(instr_i),
    .file_rdata_i(file_rdata_i), .file_is_io_i(file_is_io_i), .pin_level_i(pin_level_i),
    .acc_o(acc_o), .status_o(status_o), .file_wr_o(file_wr_o), .skip_o(skip_o));
  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // One word with a gap after it; outputs read once the answer edge settles
  task automatic op(input logic [13:0] w, input logic [7:0] r, input logic io);
    @(posedge ref_clk_i);
    instr_i <= {1'b1, w};
    file_rdata_i <= r;
    file_is_io_i <= io;
    @(posedge ref_clk_i);
    instr_i.valid <= 1'b0;
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic t_lit;
    op(14'h3900, 8'h00, 1'b0);
    chk(8'(status_o), 8'h01);
    op(14'h3EFF, 8'h00, 1'b0);
    chk(acc_o, 8'hFF);
    op(14'h3E01, 8'h00, 1'b0);
    chk({status_o, acc_o[4:0]}, 8'hE0);
    $display("literal test done");
  endtask
  task automatic t_reg;
    op(14'h07FF, 8'h0F, 1'b0);
    chk({file_wr_o.en, file_wr_o.addr}, 8'hFF);
    chk(file_wr_o.data, 8'h0F);
    op(14'h0705, 8'h81, 1'b0);
    chk(acc_o, 8'h81);
    op(14'h0583, 8'hC1, 1'b0);
    chk(file_wr_o.data, 8'h81);
    op(14'h0505, 8'h7E, 1'b0);
    chk({status_o, acc_o[4:0]}, 8'h20);
    $display("register test done");
  endtask
  // Every bit position, on opposite starting values
  task automatic t_bits;
    for (int b = 0; b < 8; b++) begin
      op(14'h1011 | 14'(b << 7), 8'hFF, 1'b0);
      chk(file_wr_o.data, ~(8'h01 << b));
      op(14'h1411 | 14'(b << 7), 8'h00, 1'b0);
      chk({status_o, file_wr_o.data[4:0]}, {3'h1, 5'(8'h01 << b)});
    end
    $display("bit test done");
  endtask
  // Taken skip drops the next add even across a gap
  task automatic t_skip;
    op(14'h1980, 8'h00, 1'b0);
    chk(8'(skip_o), 8'h01);
    op(14'h3E01, 8'h00, 1'b0);
    op(14'h1980, 8'h08, 1'b0);
    op(14'h3E01, 8'h00, 1'b0);
    chk(acc_o, 8'h01);
    op(14'h1D80, 8'h08, 1'b0);
    op(14'h3E01, 8'h00, 1'b0);
    op(14'h1D80, 8'h00, 1'b0);
    chk(8'(skip_o), 8'h00);
    op(14'h3E01, 8'h00, 1'b0);
    chk(acc_o, 8'h02);
    $display("skip test done");
  endtask
  task automatic t_io;
    @(posedge ref_clk_i);
    pin_level_i <= 8'h3C;
    repeat (3) @(posedge ref_clk_i);
    op(14'h1406, 8'hFF, 1'b1);
    chk(file_wr_o.data, 8'h3D);
    $display("pin test done");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Run is under 80 cycles; far longer means a hang
  initial begin
    #50us;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_lit();
    t_reg();
    t_bits();
    t_skip();
    t_io();
    give_verdict();
  end
endmodule // tb
